// ===== verilog/fpk_regs.sv
// Behaviour
// - The unlock key register is write-only and every read of it returns zero.
// - Software writes the unlock key as part of an unlock sequence that the device needs before it will start an operation.
// - For a whole-array erase the target address register is ignored and no address is passed on.
// - For a page erase the target address selects the single page to erase.
// - For a row program the target address selects the row to program.
// - For a word program the target address selects the single word to write.
// - The program data register is a 32-bit read/write word holding the data to program.
// - The program data register is cleared only by power-on reset, never by the system reset.
// - For row programming the data is fetched from the address in the row source address register.
`timescale 1ns/10ps
`default_nettype none
module fpk_regs (
  // clock and resets
  input wire logic clk_in,
  input wire logic nrst_in,
  input wire logic por_nrst_in,
  // register port
  input wire logic [7:0] addr_in,
  input wire logic [31:0] wdata_in,
  input wire logic wr_in,
  input wire logic rd_in,
  output logic [31:0] rdata_out,
  // control register side
  input wire logic [3:0] op_sel_in,
  input wire logic start_req_in,
  // flash array side
  output logic op_go_out,
  output logic [3:0] op_code_out,
  output logic [31:0] op_addr_out,
  output logic [31:0] op_data_out,
  output logic [31:0] op_src_out,
  output logic unlocked_out
);

  typedef struct packed {
    logic key_stage;
    logic unlocked;
    logic [31:0] tgt_addr;
    logic [31:0] src_addr;
    logic [31:0] rdata;
    logic go;
    logic [3:0] op;
    logic [31:0] op_addr;
    logic [31:0] op_data;
    logic [31:0] op_src;
  } fpk_state_type;

  typedef struct packed {
    logic [31:0] data;
  } fpk_por_type;

  fpk_state_type st_r;
  fpk_state_type st_nxt;
  fpk_por_type por_r;
  fpk_por_type por_nxt;

  logic known_op;
  logic start_ok;
  logic key_done;
  logic [31:0] masked_addr;

  always_comb begin
    known_op = (op_sel_in == fpk_pkg::OP_WORD_PROG) || (op_sel_in == fpk_pkg::OP_ROW_PROG) ||
               (op_sel_in == fpk_pkg::OP_PAGE_ERASE) || (op_sel_in == fpk_pkg::OP_ARRAY_ERASE);
    start_ok = start_req_in && st_r.unlocked && known_op;
    key_done = wr_in && (addr_in == fpk_pkg::OFS_KEY) && st_r.key_stage && (wdata_in == fpk_pkg::KEY_SECOND);
    unique case (op_sel_in)
      fpk_pkg::OP_WORD_PROG: masked_addr = st_r.tgt_addr & fpk_pkg::WORD_MASK;
      fpk_pkg::OP_ROW_PROG: masked_addr = st_r.tgt_addr & fpk_pkg::ROW_MASK;
      fpk_pkg::OP_PAGE_ERASE: masked_addr = st_r.tgt_addr & fpk_pkg::PAGE_MASK;
      default: masked_addr = fpk_pkg::RST_WORD;
    endcase
  end

  always_comb begin
    st_nxt = st_r;
    por_nxt = por_r;
    st_nxt.go = 1'b0;
    st_nxt.rdata = fpk_pkg::RST_WORD;
    // unlock: two key words back to back among register writes
    if (wr_in) begin
      if (addr_in == fpk_pkg::OFS_KEY) begin
        if (key_done) begin
          st_nxt.unlocked = 1'b1;
          st_nxt.key_stage = 1'b0;
        end else begin
          st_nxt.key_stage = (wdata_in == fpk_pkg::KEY_FIRST);
        end
      end else begin
        st_nxt.key_stage = 1'b0;
      end
      if (addr_in == fpk_pkg::OFS_ADDR) begin
        st_nxt.tgt_addr = wdata_in;
      end
      if (addr_in == fpk_pkg::OFS_SRC) begin
        st_nxt.src_addr = wdata_in;
      end
      if (addr_in == fpk_pkg::OFS_DATA) begin
        por_nxt.data = wdata_in;
      end
    end
    if (rd_in) begin
      unique case (addr_in)
        fpk_pkg::OFS_KEY: st_nxt.rdata = fpk_pkg::RST_WORD;
        fpk_pkg::OFS_ADDR: st_nxt.rdata = st_r.tgt_addr;
        fpk_pkg::OFS_DATA: st_nxt.rdata = por_r.data;
        fpk_pkg::OFS_SRC: st_nxt.rdata = st_r.src_addr;
        fpk_pkg::OFS_STAT: begin
          st_nxt.rdata[fpk_pkg::STAT_UNLOCKED_BIT] = st_r.unlocked;
          st_nxt.rdata[fpk_pkg::STAT_KEY_STAGE_BIT] = st_r.key_stage;
        end
        default: st_nxt.rdata = fpk_pkg::RST_WORD;
      endcase
    end
    // a start consumes the unlock, but a key pair completing in the same cycle wins
    if (start_ok) begin
      st_nxt.go = 1'b1;
      st_nxt.unlocked = key_done;
      st_nxt.op = op_sel_in;
      st_nxt.op_addr = masked_addr;
      st_nxt.op_data = (op_sel_in == fpk_pkg::OP_WORD_PROG) ? por_r.data : fpk_pkg::RST_WORD;
      st_nxt.op_src = (op_sel_in == fpk_pkg::OP_ROW_PROG) ? st_r.src_addr : fpk_pkg::RST_WORD;
    end
  end

  always_ff @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

  // data word survives every reset except power-on
  always_ff @(posedge clk_in or negedge por_nrst_in) begin
    if (!por_nrst_in) begin
      por_r <= '0;
    end else begin
      por_r <= por_nxt;
    end
  end

  assign rdata_out = st_r.rdata;
  assign op_go_out = st_r.go;
  assign op_code_out = st_r.op;
  assign op_addr_out = st_r.op_addr;
  assign op_data_out = st_r.op_data;
  assign op_src_out = st_r.op_src;
  assign unlocked_out = st_r.unlocked;

  // ---- checks ----
  sequence s_key_pair;
    wr_in && addr_in == fpk_pkg::OFS_KEY && wdata_in == fpk_pkg::KEY_FIRST
    ##1 wr_in && addr_in == fpk_pkg::OFS_KEY && wdata_in == fpk_pkg::KEY_SECOND;
  endsequence

  sequence s_start_seen;
    start_req_in && known_op && st_r.unlocked;
  endsequence

  a_key_reads_zero: assert property (@(posedge clk_in) disable iff (!nrst_in)
    rd_in && addr_in == fpk_pkg::OFS_KEY |=> rdata_out == 32'h0000_0000)
    else $error("key register read returned nonzero");

  a_unlock_after_pair: assert property (@(posedge clk_in) disable iff (!nrst_in)
    s_key_pair |=> unlocked_out)
    else $error("key pair did not unlock");

  a_go_needs_unlock: assert property (@(posedge clk_in) disable iff (!nrst_in)
    op_go_out |-> $past(unlocked_out) && (!unlocked_out || $past(key_done)))
    else $error("operation started while locked");

  a_erase_addr_zero: assert property (@(posedge clk_in) disable iff (!nrst_in)
    op_go_out && op_code_out == fpk_pkg::OP_ARRAY_ERASE |-> op_addr_out == 32'h0000_0000)
    else $error("array erase passed an address");

  a_page_addr_used: assert property (@(posedge clk_in) disable iff (!nrst_in)
    s_start_seen ##0 op_sel_in == fpk_pkg::OP_PAGE_ERASE
    |=> op_go_out && op_addr_out == ($past(st_r.tgt_addr) & fpk_pkg::PAGE_MASK))
    else $error("page erase address wrong");

  a_row_addr_used: assert property (@(posedge clk_in) disable iff (!nrst_in)
    s_start_seen ##0 op_sel_in == fpk_pkg::OP_ROW_PROG
    |=> op_addr_out == ($past(st_r.tgt_addr) & fpk_pkg::ROW_MASK) && op_src_out == $past(st_r.src_addr))
    else $error("row program address or source wrong");

  a_word_addr_used: assert property (@(posedge clk_in) disable iff (!nrst_in)
    s_start_seen ##0 op_sel_in == fpk_pkg::OP_WORD_PROG
    |=> op_addr_out == ($past(st_r.tgt_addr) & fpk_pkg::WORD_MASK) && op_data_out == $past(por_r.data))
    else $error("word program address or data wrong");

  a_data_write_read: assert property (@(posedge clk_in) disable iff (!nrst_in || !por_nrst_in)
    wr_in && addr_in == fpk_pkg::OFS_DATA ##1 rd_in && addr_in == fpk_pkg::OFS_DATA
    |=> rdata_out == $past(wdata_in, 2))
    else $error("data register readback wrong");

  a_data_keeps_sysrst: assert property (@(posedge clk_in) disable iff (!por_nrst_in)
    !nrst_in |=> por_r.data == $past(por_r.data))
    else $error("system reset disturbed the data word");

  // read data stand only in the cycle after a read strobe
  a_rdata_idle_zero: assert property (@(posedge clk_in) disable iff (!nrst_in)
    !rd_in |=> rdata_out == fpk_pkg::RST_WORD)
    else $error("read data present without a read");

  a_locked_no_go: assert property (@(posedge clk_in) disable iff (!nrst_in)
    !unlocked_out |=> !op_go_out)
    else $error("operation accepted without unlock");

  // operands only move together with an accepted start
  a_ops_hold: assert property (@(posedge clk_in) disable iff (!nrst_in)
    !op_go_out |-> $stable(op_addr_out) && $stable(op_data_out) && $stable(op_src_out) && $stable(op_code_out))
    else $error("operands changed without a start");

  a_array_no_operands: assert property (@(posedge clk_in) disable iff (!nrst_in)
    op_go_out && op_code_out == fpk_pkg::OP_ARRAY_ERASE |-> op_data_out == fpk_pkg::RST_WORD && op_src_out == fpk_pkg::RST_WORD)
    else $error("array erase passed operands");

endmodule // fpk_regs
`default_nettype wire

// ===== inc/fpk_pkg.sv
`default_nettype none
package fpk_pkg;
  // register offsets (byte addresses, one aligned word each)
  localparam logic [7:0] OFS_KEY = 8'h00;
  localparam logic [7:0] OFS_ADDR = 8'h04;
  localparam logic [7:0] OFS_DATA = 8'h08;
  localparam logic [7:0] OFS_SRC = 8'h0C;
  localparam logic [7:0] OFS_STAT = 8'h10;
  // status register fields
  localparam int STAT_UNLOCKED_BIT = 0;
  localparam int STAT_KEY_STAGE_BIT = 1;
  // unlock key pair, written in this order (values arbitrary)
  localparam logic [31:0] KEY_FIRST = 32'hA5A5_0F0F;
  localparam logic [31:0] KEY_SECOND = 32'h5A5A_F0F0;
  // operation_select encodings
  localparam logic [3:0] OP_NONE = 4'h0;
  localparam logic [3:0] OP_WORD_PROG = 4'h1;
  localparam logic [3:0] OP_ROW_PROG = 4'h3;
  localparam logic [3:0] OP_PAGE_ERASE = 4'h4;
  localparam logic [3:0] OP_ARRAY_ERASE = 4'h5;
  // alignment masks of the target address per operation
  localparam logic [31:0] WORD_MASK = 32'hFFFF_FFFC;
  localparam logic [31:0] ROW_MASK = 32'hFFFF_FE00;
  localparam logic [31:0] PAGE_MASK = 32'hFFFF_F000;
  // reset values
  localparam logic [31:0] RST_WORD = 32'h0000_0000;
endpackage
`default_nettype wire

// ===== tb/tb_fpk_regs.sv
`timescale 1ns/10ps
`default_nettype none
module tb_fpk_regs;
  localparam logic [7:0] KA = fpk_pkg::OFS_KEY;
  localparam logic [7:0] AA = fpk_pkg::OFS_ADDR;
  localparam logic [7:0] DA = fpk_pkg::OFS_DATA;
  localparam logic [7:0] SA = fpk_pkg::OFS_SRC;
  logic clk_in = 1'b0;
  logic nrst_in = 1'b0;
  logic por_nrst_in = 1'b0;
  logic [7:0] addr_in = 8'h00;
  logic [31:0] wdata_in = 32'h0;
  logic wr_in = 1'b0;
  logic rd_in = 1'b0;
  logic [3:0] op_sel_in = 4'h0;
  logic start_req_in = 1'b0;
  logic [31:0] rdata_out, op_addr_out, op_data_out, op_src_out;
  logic [3:0] op_code_out;
  logic op_go_out, unlocked_out;
  integer seed = 32'hFC7DDE95;
  int error_cnt = 0;
  int num_checks = 0;
  // model of the software-visible registers
  logic [31:0] m_addr, m_data, m_src;
  logic [3:0] ops [4] = '{fpk_pkg::OP_WORD_PROG, fpk_pkg::OP_ROW_PROG, fpk_pkg::OP_PAGE_ERASE, fpk_pkg::OP_ARRAY_ERASE};
  logic [31:0] masks [4] = '{fpk_pkg::WORD_MASK, fpk_pkg::ROW_MASK, fpk_pkg::PAGE_MASK, 32'h0};
  always #12.5 clk_in = ~clk_in;
  fpk_regs DUT (.clk_in(clk_in), .nrst_in(nrst_in), .por_nrst_in(por_nrst_in), .addr_in(addr_in),
    .wdata_in(wdata_in), .wr_in(wr_in), .rd_in(rd_in), .rdata_out(rdata_out), .op_sel_in(op_sel_in),
    .start_req_in(start_req_in), .op_go_out(op_go_out), .op_code_out(op_code_out), .op_addr_out(op_addr_out),
    .op_data_out(op_data_out), .op_src_out(op_src_out), .unlocked_out(unlocked_out));
  task automatic chk(input logic [31:0] s, input logic [31:0] e);
    num_checks++;
    if (s !== e) begin
      error_cnt++;
      $display("wrong value at %0t: seen %h expected %h", $time, s, e);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    addr_in <= a; wdata_in <= d; wr_in <= 1'b1;
    @(posedge clk_in); wr_in <= 1'b0;
    @(posedge clk_in);
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    addr_in <= a; rd_in <= 1'b1;
    @(posedge clk_in); rd_in <= 1'b0;
    #1 chk(rdata_out, e);
    @(posedge clk_in);
  endtask
  // start request; acc says whether an unlocked, accepted start is expected
  task automatic start(input logic [3:0] op, input logic [31:0] mask, input logic acc);
    #1 chk({31'h0, unlocked_out}, {31'h0, acc});
    @(posedge clk_in); op_sel_in <= op; start_req_in <= 1'b1;
    @(posedge clk_in); start_req_in <= 1'b0;
    #1 chk({31'h0, op_go_out}, {31'h0, acc});
    if (acc) begin
      chk({28'h0, op_code_out}, {28'h0, op});
      chk(op_addr_out, m_addr & mask);
      chk(op_data_out, (op == fpk_pkg::OP_WORD_PROG) ? m_data : 32'h0);
      chk(op_src_out, (op == fpk_pkg::OP_ROW_PROG) ? m_src : 32'h0);
      chk({31'h0, unlocked_out}, 32'h0);
    end
    @(posedge clk_in);
    #1 chk({31'h0, op_go_out}, 32'h0);
    @(posedge clk_in);
  endtask
  task automatic end_sim;
    if (error_cnt == 0 && num_checks > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  initial begin
    #200000;
    error_cnt++;
    end_sim;
  end
  initial begin
    repeat (5) @(posedge clk_in);
    nrst_in <= 1'b1; por_nrst_in <= 1'b1;
    @(posedge clk_in);
    rd(KA, 32'h0);
    rd(AA, 32'h0);
    rd(DA, 32'h0);
    rd(SA, 32'h0);
    rd(8'hFC, 32'h0);
    start(fpk_pkg::OP_PAGE_ERASE, 32'h0, 1'b0);
    for (int i = 0; i < 4; i++) begin
      m_addr = $random(seed); m_data = $random(seed); m_src = $random(seed);
      wr(AA, m_addr); wr(DA, m_data); wr(SA, m_src);
      rd(AA, m_addr);
      rd(DA, m_data);
      rd(SA, m_src);
      wr(KA, fpk_pkg::KEY_FIRST);
      rd(KA, 32'h0);
      rd(fpk_pkg::OFS_STAT, 32'h1 << fpk_pkg::STAT_KEY_STAGE_BIT);
      wr(KA, fpk_pkg::KEY_SECOND);
      rd(fpk_pkg::OFS_STAT, 32'h1 << fpk_pkg::STAT_UNLOCKED_BIT);
      start(ops[i], masks[i], 1'b1);
    end
    // back-to-back write and read of the data word
    m_data = $random(seed);
    addr_in <= DA; wdata_in <= m_data; wr_in <= 1'b1;
    @(posedge clk_in); wr_in <= 1'b0; rd_in <= 1'b1;
    @(posedge clk_in); rd_in <= 1'b0;
    #1 chk(rdata_out, m_data);
    @(posedge clk_in);
    // an unknown operation code is refused and keeps the unlock
    wr(KA, fpk_pkg::KEY_FIRST); wr(KA, fpk_pkg::KEY_SECOND);
    op_sel_in <= fpk_pkg::OP_NONE; start_req_in <= 1'b1;
    @(posedge clk_in); start_req_in <= 1'b0;
    #1 chk({31'h0, op_go_out}, 32'h0);
    chk({31'h0, unlocked_out}, 32'h1);
    @(posedge clk_in);
    start(fpk_pkg::OP_WORD_PROG, fpk_pkg::WORD_MASK, 1'b1);
    // a foreign write between the key words breaks the sequence
    wr(KA, fpk_pkg::KEY_FIRST); wr(DA, m_data); wr(KA, fpk_pkg::KEY_SECOND);
    start(fpk_pkg::OP_WORD_PROG, 32'h0, 1'b0);
    wr(KA, fpk_pkg::KEY_SECOND); wr(KA, fpk_pkg::KEY_FIRST);
    start(fpk_pkg::OP_WORD_PROG, 32'h0, 1'b0);
    // system reset alone keeps the data word, power-on reset clears it
    nrst_in <= 1'b0; repeat (2) @(posedge clk_in); nrst_in <= 1'b1; @(posedge clk_in);
    rd(DA, m_data);
    rd(AA, 32'h0);
    nrst_in <= 1'b0; por_nrst_in <= 1'b0; repeat (2) @(posedge clk_in);
    nrst_in <= 1'b1; por_nrst_in <= 1'b1; @(posedge clk_in);
    rd(DA, 32'h0);
    end_sim;
  end
endmodule // tb_fpk_regs
`default_nettype wire
